// ===== shub_pkg.sv
// Constants and types shared by the sensor hub serial port.
// Assumes nothing of its surroundings; referenced by the port, its checker and the bench.
package shub_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_CNT = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] SEL_CNT = 6'h01;
    localparam logic [1:0] DEV_ADDR = 2'h0;
    localparam int DEV_HI = 31;
    localparam int DEV_LO = 30;
    localparam int ADDR_HI = 29;
    localparam int ADDR_LO = 24;
    localparam int RW_POS = 23;
    localparam int WDATA_HI = 20;
    localparam int WDATA_LO = 5;
    localparam int CRC_HI = 4;
    localparam int CRC_LO = 2;
    localparam int MOSI_CRC_LEN = 27;
    localparam int MISO_CRC_LEN = 24;
    localparam int MISO_CRC_TOP = 26;
    localparam logic [5:0] ADDR_LAST = 6'h3b;

    // ------------------------------------------------------------
    // Addresses handled inside the port itself
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_STATUS_REG_ONE = 6'h01;
    localparam logic [5:0] ADDR_STATUS_REG_THREE = 6'h03;
    localparam logic [5:0] ADDR_PORT_CFG = 6'h3a;
    localparam int MUX_DIS_BIT = 0;

    // ------------------------------------------------------------
    // CRC
    // ------------------------------------------------------------
    localparam logic [2:0] CRC_INIT = 3'h7;
    localparam logic [2:0] CRC_INV_MASK = 3'h3;

    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } shub_reg_req_t;

    typedef struct packed {
        logic [11:0] status_reg_one_faults;
        logic [14:0] status_reg_two_faults;
        logic reset_cause;
        logic programming_done;
        logic buf_empty_err;
    } shub_status_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic read_only;
        logic slot_err;
        logic order_err;
        logic [2:0] sensor_crc;
    } shub_reg_rsp_t;

    typedef enum logic [1:0] {
        SHUB_IDLE = 2'h0,
        SHUB_ACTIVE = 2'h1,
        SHUB_EXEC = 2'h3
    } shub_state_t;

endpackage

// ===== shub_sync.sv
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that stays put for several clock periods.
`timescale 1ns/1ns
`default_nettype none
module shub_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ===== shub_spi_slave.sv
// Serial register port of the sensor hub: 32-bit frames, 3-bit CRC both ways.
// Assumes the register bank and the sensor logic sit beside it on clk.
`timescale 1ns/1ns
`default_nettype none
module shub_spi_slave (
    // System clock, reset and clock enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Device reset sources
    input wire logic software_reset_cmd_i,
    input wire logic clk_fault_i,
    // Configuration and status from the device
    input wire logic crc_from_port_i,
    input var shub_pkg::shub_status_t status_i,
    // Register bank access
    output var shub_pkg::shub_reg_req_t reg_req_o,
    input var shub_pkg::shub_reg_rsp_t reg_rsp_i,
    // Port state
    output logic port_error_flag_o,
    output logic port_fail_set_o,
    output logic reset_indication_o,
    output logic mux_mode_o
);

    // ------------------------------------------------------------
    // CRC helper
    // ------------------------------------------------------------
    // shared CRC engine
    function automatic logic [2:0] crc3(input logic [31:0] d, input int n);
        logic [2:0] c;
        logic fb;
        c = shub_pkg::CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < n + 3; i++) begin
            fb = c[2] ^ ((i < n) ? d[31-i] : 1'b0);
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Link side, clocked by the serial clock
    // ------------------------------------------------------------
    shub_pkg::shub_state_t state_q;
    logic link_rst_n;
    logic [31:0] rx_q;
    logic [5:0] cnt_q;
    logic [4:0] idx_q;
    logic sel_q;
    logic [31:0] tx_q;

    // The link side is cleared only once the system side has taken the
    // frame, so select going high alone does not wipe it before capture.
    assign link_rst_n = rst_n & ~(cs_n_i & (state_q == shub_pkg::SHUB_IDLE));

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_q <= '0;
        end else begin
            rx_q <= {rx_q[30:0], mosi_i};
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_q <= '0;
        end else if (cnt_q != shub_pkg::CNT_MAX) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sel_q <= 1'b0;
        end else if (cnt_q == shub_pkg::SEL_CNT) begin
            sel_q <= ({rx_q[0], mosi_i} == shub_pkg::DEV_ADDR);
        end
    end

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            idx_q <= '0;
        end else begin
            idx_q <= idx_q + 5'h01;
        end
    end

    // most significant bit first
    // The reply word is frozen for the whole frame, so this select
    // needs no crossing; it is the one output not taken from a flop.
    assign miso_o = tx_q[5'h1f - idx_q];

    // ------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------
    logic cs_sel_s;
    logic sel_s;

    shub_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d_i({~cs_n_i, sel_q}),
        .q_o({cs_sel_s, sel_s})
    );

    logic cs_act;
    assign cs_act = cs_sel_s;

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    logic mux_mode_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= shub_pkg::SHUB_IDLE;
        end else if (ce_i) begin
            unique case (state_q)
                shub_pkg::SHUB_IDLE: begin
                    if (cs_act) begin
                        state_q <= shub_pkg::SHUB_ACTIVE;
                    end
                end
                shub_pkg::SHUB_ACTIVE: begin
                    if (!cs_act) begin
                        state_q <= shub_pkg::SHUB_EXEC;
                    end
                end
                shub_pkg::SHUB_EXEC: begin
                    state_q <= shub_pkg::SHUB_IDLE;
                end
                default: begin
                    state_q <= shub_pkg::SHUB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_oe_o <= 1'b0;
        end else if (ce_i) begin
            miso_oe_o <= cs_act & (~mux_mode_q | sel_s);
        end
    end

    // ------------------------------------------------------------
    // Frame decode, read once the link side is quiet
    // ------------------------------------------------------------
    logic exec;
    logic [5:0] f_addr;
    logic f_write;
    logic [15:0] f_wdata;
    logic count_ok;
    logic crc_ok;
    logic addressed;
    logic bad_addr;
    logic illegal_op;
    logic frame_err;
    logic frame_ok;

    assign exec = ce_i & (state_q == shub_pkg::SHUB_EXEC);
    assign f_addr = rx_q[shub_pkg::ADDR_HI:shub_pkg::ADDR_LO];
    assign f_write = rx_q[shub_pkg::RW_POS];
    assign f_wdata = rx_q[shub_pkg::WDATA_HI:shub_pkg::WDATA_LO];
    assign count_ok = (cnt_q == shub_pkg::FRAME_CNT);
    assign crc_ok = (crc3(rx_q, shub_pkg::MOSI_CRC_LEN) == rx_q[shub_pkg::CRC_HI:shub_pkg::CRC_LO]);
    assign addressed = ~mux_mode_q |
        (rx_q[shub_pkg::DEV_HI:shub_pkg::DEV_LO] == shub_pkg::DEV_ADDR) | ~count_ok;
    assign bad_addr = (f_addr > shub_pkg::ADDR_LAST);
    assign illegal_op = f_write & reg_rsp_i.read_only & (f_addr != shub_pkg::ADDR_PORT_CFG);
    assign frame_err = ~count_ok | ~crc_ok | illegal_op;
    assign frame_ok = exec & addressed & ~frame_err;

    // ------------------------------------------------------------
    // Register requests
    // ------------------------------------------------------------
    // execute only valid frames
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_req_o <= '0;
        end else if (ce_i) begin
            reg_req_o.wr <= frame_ok & f_write & ~bad_addr;
            reg_req_o.rd <= frame_ok & ~f_write & ~bad_addr;
            if (exec) begin
                reg_req_o.addr <= f_addr;
                reg_req_o.wdata <= f_wdata;
            end
        end
    end

    // Read data returns in the following frame, as the bank answers
    // one cycle after the strobe.
    logic [15:0] rdata_q;
    logic [5:0] raddr_q;
    logic rd_wait_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait_q <= 1'b0;
            rdata_q <= '0;
            raddr_q <= '0;
        end else if (ce_i) begin
            rd_wait_q <= reg_req_o.rd;
            if (exec & addressed) begin
                raddr_q <= f_addr;
            end
            if (rd_wait_q) begin
                rdata_q <= reg_rsp_i.rdata;
            end
        end
    end

    logic inv_crc_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inv_crc_q <= 1'b0;
        end else if (ce_i & exec & addressed) begin
            inv_crc_q <= bad_addr | illegal_op | reg_rsp_i.slot_err | reg_rsp_i.order_err;
        end
    end

    // ------------------------------------------------------------
    // Port mode and status flags
    // ------------------------------------------------------------
    // reset enters multiplexing mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_mode_q <= 1'b1;
        end else if (ce_i) begin
            if (software_reset_cmd_i | clk_fault_i) begin
                mux_mode_q <= 1'b1;
            end else if (frame_ok & f_write & (f_addr == shub_pkg::ADDR_PORT_CFG)) begin
                mux_mode_q <= ~f_wdata[shub_pkg::MUX_DIS_BIT];
            end
        end
    end

    // flag set by bad frame
    // A new error in the same cycle as the clearing read wins.
    logic err_set;
    assign err_set = exec & addressed & frame_err;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_error_flag_o <= 1'b0;
            port_fail_set_o <= 1'b0;
        end else if (ce_i) begin
            port_fail_set_o <= err_set;
            if (err_set) begin
                port_error_flag_o <= 1'b1;
            end else if (reg_req_o.rd & (reg_req_o.addr == shub_pkg::ADDR_STATUS_REG_ONE)) begin
                port_error_flag_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_indication_o <= 1'b1;
        end else if (ce_i) begin
            if (software_reset_cmd_i) begin
                reset_indication_o <= 1'b1;
            end else if (reg_req_o.rd & (reg_req_o.addr == shub_pkg::ADDR_STATUS_REG_THREE) & ~status_i.reset_cause) begin
                reset_indication_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_mode_o <= 1'b1;
        end else if (ce_i) begin
            mux_mode_o <= mux_mode_q;
        end
    end

    // ------------------------------------------------------------
    // Reply word
    // ------------------------------------------------------------
    logic fsum1;
    logic fsum2;
    logic gstat;
    logic [5:0] gbits;
    logic [31:0] reply;
    logic [2:0] reply_crc;

    assign fsum1 = |status_i.status_reg_one_faults;
    assign fsum2 = |status_i.status_reg_two_faults[14:8] | |status_i.status_reg_two_faults[6:0];
    assign gstat = port_error_flag_o | fsum1 | fsum2 | reset_indication_o |
        status_i.programming_done | status_i.buf_empty_err;

    always_comb begin
        gbits = {port_error_flag_o, fsum1, fsum2, reset_indication_o, status_i.programming_done, gstat};
        if (mux_mode_q) begin
            gbits[5:3] = 3'h0;
        end
    end

    always_comb begin
        reply = {gbits, 2'h0, raddr_q, rdata_q[14:0], 3'h0};
        reply_crc = crc_from_port_i ?
            crc3({reply[shub_pkg::MISO_CRC_TOP:0], 5'h00}, shub_pkg::MISO_CRC_LEN) :
            reg_rsp_i.sensor_crc;
        if (inv_crc_q) begin
            reply_crc = reply_crc ^ shub_pkg::CRC_INV_MASK;
        end
        reply[2:0] = reply_crc;
    end

    // The reply is sampled only while deselected, so it stays fixed
    // through the frame; status changing mid-frame shows next time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= '0;
        end else if (ce_i & ~cs_act & (state_q == shub_pkg::SHUB_IDLE)) begin
            tx_q <= reply;
        end
    end

endmodule
`default_nettype wire

// ===== shub_spi_slave_assertions.sv
// Port checks for the sensor hub serial port.
// Assumes select stays high six cycles or more between frames.
`timescale 1ns/1ns
`default_nettype none
module shub_spi_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs seen by the port
    input wire logic cs_n_i,
    input wire logic software_reset_cmd_i,
    input wire logic clk_fault_i,
    input var shub_pkg::shub_status_t status_i,
    // Outputs of the port
    input var shub_pkg::shub_reg_req_t reg_req_o,
    input wire logic miso_oe_o,
    input wire logic port_error_flag_o,
    input wire logic port_fail_set_o,
    input wire logic reset_indication_o,
    input wire logic mux_mode_o
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------
    // Properties
    // ----------
    a_oe_idle: assert property (cs_n_i [*5] |-> !miso_oe_o)
        else $error("data out driven while deselected");
    a_oe_start: assert property ($fell(cs_n_i) && !mux_mode_o |-> ##[1:4] miso_oe_o)
        else $error("data out not driven after select");
    a_fail_flag: assert property (port_fail_set_o |=> port_error_flag_o [*3])
        else $error("error flag not set after failure");
    a_fail_discard: assert property (port_fail_set_o |-> (!reg_req_o.wr) [*4])
        else $error("bad frame still written");
    a_req_framed: assert property (reg_req_o.wr || reg_req_o.rd |-> cs_n_i && $past(cs_n_i, 2))
        else $error("register access before frame end");
    a_one_op: assert property ($rose(reg_req_o.wr) |=> !reg_req_o.wr && !reg_req_o.rd)
        else $error("more than one access per frame");
    a_software_reset_cmd: assert property (software_reset_cmd_i |-> ##[1:3] reset_indication_o && mux_mode_o)
        else $error("software reset not taken");
    a_fault_mux: assert property (clk_fault_i |-> ##[1:3] mux_mode_o)
        else $error("clock fault did not restore mux mode");
    a_ind_hold: assert property ($fell(reset_indication_o) |-> !status_i.reset_cause)
        else $error("reset indication cleared with cause present");
    a_err_hold: assert property ($fell(port_error_flag_o) |-> !$past(port_fail_set_o))
        else $error("error flag cleared over a new failure");
endmodule

bind shub_spi_slave shub_spi_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_n_i(cs_n_i),
    .software_reset_cmd_i(software_reset_cmd_i), .clk_fault_i(clk_fault_i), .status_i(status_i),
    .reg_req_o(reg_req_o), .miso_oe_o(miso_oe_o), .port_error_flag_o(port_error_flag_o),
    .port_fail_set_o(port_fail_set_o), .reset_indication_o(reset_indication_o), .mux_mode_o(mux_mode_o));
`default_nettype wire

// ===== shub_master_model.sv
// Serial master model: drives select, serial clock and data in.
// Assumes the bench leaves the port time to finish each frame.
`timescale 1ns/1ns
`default_nettype none
module shub_master_model (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic [31:0] rx;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
        rx = 32'h0;
    end

    // ----------
    // Check code
    // ----------
    // seed, polynomial, zero tail.
    function automatic logic [2:0] crc3(input logic [31:0] d, input int n);
        logic [2:0] c;
        logic fb;
        c = 3'h7;
        for (int i = n + 2; i >= 0; i--) begin
            fb = c[2] ^ ((i >= 3) ? d[i - 3] : 1'b0);
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction

    // ----------
    // Frame
    // ----------
    // clock low at select edges, MSB first.
    task automatic xfer(input logic [31:0] w, input int n);
        // Step off the system clock edge so select never races its sampler.
        #2;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            rx = {rx[30:0], miso_oe ? miso : 1'bz};
            mosi = w[31 - i];
            #5 sclk = 1'b1;
            #6 sclk = 1'b0;
            #1;
        end
        #20 cs_n = 1'b1;
        // A released line flips so a stale bit never passes as data.
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// ===== test_sensor_hub_spi_slave.sv
// Self-checking bench for the sensor hub serial port.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_sensor_hub_spi_slave;
    // ----------
    // Signals
    // ----------
    logic clk, rst_n, sw_rst, clk_fault, crc_port;
    logic sclk, cs_n, mosi, miso, oe, err, fail, rst_ind, mux;
    shub_pkg::shub_status_t status;
    shub_pkg::shub_reg_req_t req;
    shub_pkg::shub_reg_rsp_t rsp;
    logic [31:0] rx;
    logic [5:0] rd_addr;
    logic [21:0] wr_word;
    int error_cnt, n_compared, n_wr, n_rd, n_fail, n_oe, k;

    shub_spi_slave uut (.clk(clk), .rst_n(rst_n), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe), .software_reset_cmd_i(sw_rst),
        .clk_fault_i(clk_fault), .crc_from_port_i(crc_port), .status_i(status), .reg_req_o(req),
        .reg_rsp_i(rsp), .port_error_flag_o(err), .port_fail_set_o(fail),
        .reset_indication_o(rst_ind), .mux_mode_o(mux));
    shub_master_model m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        n_wr <= n_wr + int'(req.wr);
        n_rd <= n_rd + int'(req.rd);
        n_fail <= n_fail + int'(fail);
        n_oe <= n_oe + int'(oe);
        if (req.rd) begin
            rd_addr <= req.addr;
        end
        if (req.wr) begin
            wr_word <= {req.addr, req.wdata};
        end
    end

    // ----------
    // Helpers
    // ----------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic frame(input logic [5:0] a, input logic rw, input logic [15:0] wd, input int n,
                         input logic [2:0] flip, input logic [1:0] dev = 2'h0);
        logic [26:0] h;
        h = {dev, a, rw, 2'b00, wd};
        m.xfer({h, m.crc3({5'h0, h}, 27) ^ flip, 2'b00}, n);
        repeat (12) @(posedge clk);
        rx = m.rx;
    endtask

    task automatic set_status(input logic [11:0] s1, input logic [14:0] s2, input logic rc, po, be);
        @(posedge clk);
        status <= {s1, s2, rc, po, be};
    endtask

    task automatic set_rsp(input logic ro, sl, od);
        @(posedge clk);
        rsp <= {16'hffff, ro, sl, od, 3'h5};
    endtask

    task automatic chk_crc(input logic bad);
        check(rx[2:0], m.crc3({8'h0, rx[26:3]}, 24) ^ {1'b0, bad, bad});
    endtask

    task automatic chk_reply(input logic [5:0] top, input logic mx);
        // In mux mode the first four head bits go out before the port drives the line.
        if (mx) begin
            check(rx[26], top[0]);
        end else begin
            check(rx[31:26], top);
        end
        chk_crc(1'b0);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_mux();
        check({rst_ind, mux, oe, err}, 4'b1100);
        frame(6'h10, 1'b1, 16'h1234, 32, 3'h0, 2'h1);
        check(n_wr + n_rd + n_fail + n_oe, 32'h0);
        frame(6'h10, 1'b0, 16'h0, 32, 3'h0);
        check(rd_addr, 6'h10);
        chk_reply(6'b000101, 1'b1);
        $display("mux test done");
    endtask

    task automatic t_ind();
        set_status(12'h0, 15'h0, 1'b1, 1'b0, 1'b0);
        frame(shub_pkg::ADDR_STATUS_REG_THREE, 1'b0, 16'h0, 32, 3'h0);
        check(rst_ind, 1'b1);
        set_status(12'h0, 15'h0, 1'b0, 1'b0, 1'b0);
        frame(shub_pkg::ADDR_STATUS_REG_THREE, 1'b0, 16'h0, 32, 3'h0);
        check(rst_ind, 1'b0);
        $display("indication test done");
    endtask

    task automatic t_std();
        frame(shub_pkg::ADDR_PORT_CFG, 1'b1, 16'h0001, 32, 3'h0);
        check(mux, 1'b0);
        set_status(12'h001, 15'h0080, 1'b0, 1'b0, 1'b1);
        k = n_oe;
        frame(6'h05, 1'b0, 16'h0, 32, 3'h0);
        check(n_oe - k > 45, 1'b1);
        check(rd_addr, 6'h05);
        frame(6'h06, 1'b0, 16'h0, 32, 3'h0);
        chk_reply(6'b010001, 1'b0);
        check(rx[25:3], {8'h05, 15'h7fff});
        set_status(12'h0, 15'h0100, 1'b0, 1'b1, 1'b0);
        frame(6'h06, 1'b0, 16'h0, 32, 3'h0);
        chk_reply(6'b001011, 1'b0);
        set_status(12'h0, 15'h0, 1'b0, 1'b0, 1'b0);
        $display("standard test done");
    endtask

    task automatic t_err();
        k = n_wr;
        frame(6'h10, 1'b1, 16'h55aa, 32, 3'h1);
        check(n_fail, 32'h1);
        check(err, 1'b1);
        frame(6'h10, 1'b1, 16'h55aa, 31, 3'h0);
        check(n_fail, 2);
        check(n_wr, k);
        frame(6'h10, 1'b1, 16'h55aa, 32, 3'h0);
        check(n_wr, k + 1);
        check(wr_word, {6'h10, 16'h55aa});
        chk_reply(6'b100001, 1'b0);
        frame(shub_pkg::ADDR_STATUS_REG_ONE, 1'b0, 16'h0, 32, 3'h0);
        check(err, 1'b0);
        $display("error test done");
    endtask

    task automatic t_bad();
        for (int i = 0; i < 4; i++) begin
            set_rsp(i == 0, i == 2, i == 3);
            frame((i == 1) ? 6'h3c : 6'h10, i == 0, 16'h0, 32, 3'h0);
            set_rsp(1'b0, 1'b0, 1'b0);
            frame(6'h06, 1'b0, 16'h0, 32, 3'h0);
            chk_crc(1'b1);
        end
        check(n_fail, 3);
        @(posedge clk);
        crc_port <= 1'b0;
        frame(6'h06, 1'b0, 16'h0, 32, 3'h0);
        check(rx[2:0], 3'h5);
        @(posedge clk);
        crc_port <= 1'b1;
        $display("bad access test done");
    endtask

    task automatic t_src();
        @(posedge clk);
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({rst_ind, mux}, 2'b11);
        frame(shub_pkg::ADDR_STATUS_REG_THREE, 1'b0, 16'h0, 32, 3'h0);
        frame(shub_pkg::ADDR_PORT_CFG, 1'b1, 16'h0001, 32, 3'h0);
        check(mux, 1'b0);
        @(posedge clk);
        clk_fault <= 1'b1;
        @(posedge clk);
        clk_fault <= 1'b0;
        repeat (4) @(posedge clk);
        check(mux, 1'b1);
        $display("reset source test done");
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        sw_rst = 1'b0;
        clk_fault = 1'b0;
        crc_port = 1'b1;
        status = '0;
        rsp = {16'hffff, 3'b000, 3'h5};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_mux();
        t_ind();
        t_std();
        t_err();
        t_bad();
        t_src();
        stop_test();
    end

    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
